/* File: serial_baud_rate_generator.sv */
// Purpose: bit-rate generator with registers on a classic wishbone slave
// Assumes: 8-bit registers in byte lane 0 of a 32-bit bus
// Notes: one wait state per access; unmapped reads return zero
//
// Notes on behaviour
// [R1] async rate: osc over 64 or 16 times (divisor+1)
// [R2] sync rate: osc over 4 times (divisor+1)
// [R3] divisor takes 0 to 255, used directly
// [R4] writing divisor clears the timer at once
// [R5] receive pin sampled thrice, majority decides
// [R6] software may prefer high speed for accuracy
// [R7] resets load the documented control and divisor values
// [R8] divisor sets period of free-running 8-bit timer
// [R9] sync mode ignores high-speed select
// [R10] prescale then timer, tick on match, restart
`timescale 1ns/1ps
module serial_baud_rate_generator #(
  parameter int ADDR_W = 10
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,

  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,

  // receive line
  input wire logic receive_data_pin,

  // status from the shift logic
  input wire logic shift_reg_empty,
  input wire logic framing_error,
  input wire logic overrun_error,
  input wire logic rx_bit9,

  // to the shift logic
  output logic bit_rate_tick,
  output logic rx_sample_level,
  output logic [7:0] transmit_control_status,
  output logic [7:0] receive_control_status,
  output logic [7:0] bit_rate_divisor
);

  // register index decode, shared by read and write paths
  function automatic logic hits(input logic [ADDR_W-1:0] adr, input logic [7:0] idx);
    hits = (adr[ADDR_W-1:2] == idx) && (adr[1:0] == 2'h0);
  endfunction : hits

  // bus slave state
  baud_pkg::bus_state_t bus_state;
  baud_pkg::bus_state_t next_bus_state;
  logic next_ack;
  logic [31:0] next_dat;

  // register state
  logic [7:0] next_tx;
  logic [7:0] next_rx;
  logic [7:0] next_div;

  // decode
  logic req;
  logic commit;
  logic wr_lane0;
  logic wr_tx;
  logic wr_rx;
  logic wr_div;

  // timer link
  logic [6:0] prescale;
  logic timer_tick;
  logic timer_sample;
  logic [7:0] timer_count;
  logic [5:0] timer_phase;
  logic mode_sync;
  logic mode_high;

  assign req = wb_cyc_i && wb_stb_i;
  // the write lands on the edge the master sees ack
  assign commit = req && (bus_state == baud_pkg::BUS_ACK);
  assign wr_lane0 = commit && wb_we_i && wb_sel_i[0];
  assign wr_tx = wr_lane0 && hits(wb_adr_i, baud_pkg::IDX_TX_CTRL);
  assign wr_rx = wr_lane0 && hits(wb_adr_i, baud_pkg::IDX_RX_CTRL);
  assign wr_div = wr_lane0 && hits(wb_adr_i, baud_pkg::IDX_DIVISOR);

  assign mode_sync = transmit_control_status[baud_pkg::TX_SYNC_BIT];
  assign mode_high = transmit_control_status[baud_pkg::TX_HIGH_SPEED_BIT];

  // prescale choice
  always_comb begin
    if (mode_sync) begin
      prescale = baud_pkg::PRESCALE_SYNC; // R2 R9
    end else if (mode_high) begin
      prescale = baud_pkg::PRESCALE_ASYNC_HIGH; // R1
    end else begin
      prescale = baud_pkg::PRESCALE_ASYNC_LOW; // R1
    end
  end

  // bus slave next state
  always_comb begin
    next_bus_state = bus_state;
    next_ack = 1'b0;
    next_dat = wb_dat_o;
    case (bus_state)
      baud_pkg::BUS_IDLE: begin
        if (req) begin
          next_bus_state = baud_pkg::BUS_ACK;
          next_ack = 1'b1;
          if (hits(wb_adr_i, baud_pkg::IDX_TX_CTRL)) begin
            next_dat = {24'h0000_00, transmit_control_status[7:2], shift_reg_empty,
                        transmit_control_status[0]};
          end else if (hits(wb_adr_i, baud_pkg::IDX_RX_CTRL)) begin
            next_dat = {24'h0000_00, receive_control_status};
          end else if (hits(wb_adr_i, baud_pkg::IDX_DIVISOR)) begin
            next_dat = {24'h0000_00, bit_rate_divisor};
          end else if (hits(wb_adr_i, baud_pkg::IDX_RATE_STATUS)) begin
            // live timer state, for software that wants to watch it run
            // 8 pad bits make exactly 32: level at bit 23, prescale at 20:14
            next_dat = {8'h00, rx_sample_level, mode_sync, mode_high, prescale, timer_phase,
                        timer_count};
          end else begin
            next_dat = 32'h0000_0000;
          end
        end
      end
      baud_pkg::BUS_ACK: begin
        // always one idle cycle after ack, so a held stb is not taken twice
        next_bus_state = baud_pkg::BUS_IDLE;
      end
      default: begin
        next_bus_state = baud_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      bus_state <= baud_pkg::BUS_IDLE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      bus_state <= next_bus_state;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // register next values
  always_comb begin
    next_tx = transmit_control_status;
    next_rx = receive_control_status;
    next_div = bit_rate_divisor;
    if (wr_tx) begin
      next_tx = (wb_dat_i[7:0] & baud_pkg::TX_WRITE_MASK) |
                (transmit_control_status & ~baud_pkg::TX_WRITE_MASK);
    end
    next_tx[baud_pkg::TX_SHIFT_EMPTY_BIT] = shift_reg_empty;
    next_tx[3] = 1'b0;
    if (wr_rx) begin
      next_rx[7:4] = wb_dat_i[7:4];
    end
    next_rx[3] = 1'b0;
    next_rx[baud_pkg::RX_FRAMING_BIT] = framing_error;
    next_rx[baud_pkg::RX_OVERRUN_BIT] = overrun_error;
    next_rx[baud_pkg::RX_BIT9_BIT] = rx_bit9;
    if (wr_div) begin
      next_div = wb_dat_i[7:0]; // R3
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      transmit_control_status <= baud_pkg::TX_CTRL_RESET; // R7
      receive_control_status <= baud_pkg::RX_CTRL_RESET; // R7
      bit_rate_divisor <= baud_pkg::DIVISOR_RESET; // R7
    end else begin
      transmit_control_status <= next_tx;
      receive_control_status <= next_rx;
      bit_rate_divisor <= next_div;
    end
  end

  // timer reads the stored divisor; the write cycle clears it
  rate_timer u_rate_timer (
    .mclk(mclk),
    .rst_b(rst_b),
    .clear(wr_div), // R4
    .prescale(prescale),
    .divisor(bit_rate_divisor), // R8
    .bit_tick(timer_tick),
    .sample_strobe(timer_sample),
    .count(timer_count),
    .phase(timer_phase)
  );

  majority_sampler u_majority_sampler (
    .mclk(mclk),
    .rst_b(rst_b),
    .clear(wr_div),
    .sample(timer_sample), // R5
    .pin(receive_data_pin),
    .level(rx_sample_level)
  );

  assign bit_rate_tick = timer_tick; // R10

endmodule : serial_baud_rate_generator

/* File: baud_pkg.sv */
// Purpose: shared constants for the serial bit-rate generator
// Assumes: register index times four gives the byte address
// Notes: prescale figures are oscillator clocks per timer step
package baud_pkg;

  // register indices, byte address is four times these
  localparam logic [7:0] IDX_RX_CTRL = 8'h18;
  localparam logic [7:0] IDX_TX_CTRL = 8'h98;
  localparam logic [7:0] IDX_DIVISOR = 8'h99;
  localparam logic [7:0] IDX_RATE_STATUS = 8'h9A;

  // values after every reset
  localparam logic [7:0] TX_CTRL_RESET = 8'h02;
  localparam logic [7:0] RX_CTRL_RESET = 8'h00;
  localparam logic [7:0] DIVISOR_RESET = 8'h00;

  // writable bits; the rest are status or unimplemented
  localparam logic [7:0] TX_WRITE_MASK = 8'hF5;
  localparam logic [7:0] RX_WRITE_MASK = 8'hF0;

  // field positions
  localparam int TX_SYNC_BIT = 4;
  localparam int TX_HIGH_SPEED_BIT = 2;
  localparam int TX_SHIFT_EMPTY_BIT = 1;
  localparam int RX_FRAMING_BIT = 2;
  localparam int RX_OVERRUN_BIT = 1;
  localparam int RX_BIT9_BIT = 0;

  // prescale before the rate timer
  localparam logic [6:0] PRESCALE_ASYNC_LOW = 7'h40;
  localparam logic [6:0] PRESCALE_ASYNC_HIGH = 7'h10;
  localparam logic [6:0] PRESCALE_SYNC = 7'h04;

  // samples taken per bit for the vote
  localparam logic [1:0] VOTE_SAMPLES = 2'h3;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

endpackage : baud_pkg

/* File: rate_timer.sv */
// Purpose: prescaler plus free-running 8-bit rate timer
// Assumes: prescale is 4, 16 or 64
// Notes: clear restarts both stages at phase zero
`timescale 1ns/1ps
module rate_timer (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // control
  input wire logic clear,
  input wire logic [6:0] prescale,
  input wire logic [7:0] divisor,
  // results
  output logic bit_tick,
  output logic sample_strobe,
  output logic [7:0] count,
  output logic [5:0] phase
);

  logic [5:0] next_phase;
  logic [7:0] next_count;
  logic next_tick;
  logic next_sample;
  logic [5:0] last;
  logic [5:0] half;
  logic in_mid;

  always_comb begin
    last = prescale[5:0] - 6'h1;
    half = prescale[6:1];
    next_phase = phase;
    next_count = count;
    next_tick = 1'b0;
    in_mid = (count == {1'b0, divisor[7:1]});
    next_sample = in_mid && (phase == half - 6'h1 || phase == half || phase == half + 6'h1);
    if (clear) begin
      next_phase = 6'h0; // R4
      next_count = 8'h0; // R4
      next_sample = 1'b0;
    end else if (phase >= last) begin
      // >= guards a mode change that shrinks the prescale mid-count
      next_phase = 6'h0; // R10
      if (count >= divisor) begin
        next_count = 8'h0; // R10
        next_tick = 1'b1; // R8
      end else begin
        next_count = count + 8'h1;
      end
    end else begin
      next_phase = phase + 6'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      phase <= 6'h0;
      count <= 8'h0;
      bit_tick <= 1'b0;
      sample_strobe <= 1'b0;
    end else begin
      phase <= next_phase;
      count <= next_count;
      bit_tick <= next_tick;
      sample_strobe <= next_sample;
    end
  end

endmodule : rate_timer

/* File: majority_sampler.sv */
// Purpose: three-sample majority vote on the receive pin
// Assumes: pin already synchronous to mclk
// Notes: level idles high, as a quiet line does
`timescale 1ns/1ps
module majority_sampler (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // sampling
  input wire logic clear,
  input wire logic sample,
  input wire logic pin,
  // result
  output logic level
);

  logic [2:0] shots;
  logic [1:0] taken;
  logic [2:0] next_shots;
  logic [1:0] next_taken;
  logic next_level;

  always_comb begin
    next_shots = shots;
    next_taken = taken;
    next_level = level;
    if (clear) begin
      next_taken = 2'h0;
    end else if (sample) begin
      next_shots = {shots[1:0], pin};
      if (taken == baud_pkg::VOTE_SAMPLES - 2'h1) begin
        next_taken = 2'h0;
        next_level = (shots[1] & shots[0]) | (shots[1] & pin) | (shots[0] & pin); // R5
      end else begin
        next_taken = taken + 2'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      shots <= 3'h7;
      taken <= 2'h0;
      level <= 1'b1;
    end else begin
      shots <= next_shots;
      taken <= next_taken;
      level <= next_level;
    end
  end

endmodule : majority_sampler

/* File: baud_checker.sv */
// Purpose: port checker for the bit-rate generator
// Assumes: default address width of ten bits
// Notes: tick period figure holds for sync mode at divisor zero only; the tick gap figures hold in every mode
`timescale 1ns/1ps
module baud_checker #(parameter int ADDR_W = 10) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // results
  input wire logic bit_rate_tick,
  input wire logic [7:0] transmit_control_status,
  input wire logic [7:0] bit_rate_divisor
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic req;
  logic dwr;
  assign req = wb_cyc_i && wb_stb_i;
  assign dwr = req && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_adr_i == 10'h264;
  sequence quiet4;
    (!req && transmit_control_status[4] && bit_rate_divisor == 8'h00) [*4];
  endsequence
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_ACK_WAIT: assert property (req && !wb_ack_o && !$past(wb_ack_o) |=> wb_ack_o) else $error("ack late");
  AST_ACK_IDLE: assert property (!req |=> !wb_ack_o) else $error("ack without request");
  AST_DIV_WRITE: assert property (dwr |=> bit_rate_divisor == $past(wb_dat_i[7:0]))
    else $error("divisor not written");
  AST_DIV_CLEAR: assert property (dwr |=> !bit_rate_tick [*3]) else $error("tick soon after write");
  AST_TICK_SYNC: assert property (bit_rate_tick ##0 quiet4 |=> bit_rate_tick)
    else $error("sync period wrong");
  AST_TICK_GAP: assert property (bit_rate_tick |=> !bit_rate_tick [*3]) else $error("ticks too close");
  AST_RD_DIV: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 10'h264 |-> wb_dat_o == {24'h0, bit_rate_divisor})
    else $error("divisor read wrong");
  AST_UNMAPPED: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 10'h3FC |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule : baud_checker

/* File: tb.sv */
// Purpose: self-checking bench for the bit-rate generator
// Assumes: one wait state per access
// Notes: vote checked on steady levels and on one-cycle glitches
`timescale 1ns/1ps
module tb;
  logic mclk = 0, rst_b = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic [9:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
  logic receive_data_pin = 1, shift_reg_empty = 1, framing_error = 0, overrun_error = 0, rx_bit9 = 0;
  logic bit_rate_tick, rx_sample_level;
  logic [7:0] transmit_control_status, receive_control_status, bit_rate_divisor, t;
  logic [7:0] mtx [5] = '{8'h14, 8'h04, 8'h00, 8'h10, 8'h10};
  int mp [5] = '{4, 16, 64, 4, 4};
  int miscompares = 0, n_tests = 0, seed = 32'hcc9d, k, d;
  serial_baud_rate_generator dut (.*);
  always #5 mclk = ~mclk;
  task automatic finish_test;
    $display("checks %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask : cmp
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] v);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, v};
    for (k = 0; k < 50 && wb_ack_o !== 1'b1; k++) @(posedge mclk);
    if (k == 50) begin
      miscompares++;
      finish_test();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge mclk);
  endtask : wb
  task automatic to_tick(input int start);
    for (k = start; k < 20000 && bit_rate_tick !== 1'b1; k++) @(posedge mclk);
    if (k == 20000) begin
      miscompares++;
      finish_test();
    end
  endtask : to_tick
  task automatic check_reset;
    rst_b <= 0;
    shift_reg_empty <= 1;
    {framing_error, overrun_error, rx_bit9} <= 3'h0;
    repeat (12) @(posedge mclk);
    rst_b <= 1;
    wb(0, baud_pkg::IDX_DIVISOR, 0);
    cmp("divisor reset", 0, rd);
    wb(0, baud_pkg::IDX_TX_CTRL, 0);
    cmp("tx reset", 32'h0000_0002, rd);
    wb(0, baud_pkg::IDX_RX_CTRL, 0);
    cmp("rx reset", 0, rd);
    cmp("tx port reset", 32'h0000_0002, {24'h0, transmit_control_status});
    cmp("rx port reset", 0, {24'h0, receive_control_status});
    cmp("divisor port reset", 0, {24'h0, bit_rate_divisor});
    $display("reset test done");
  endtask : check_reset
  initial begin
    check_reset();
    wb_sel_i <= 4'h0;
    wb(1, baud_pkg::IDX_DIVISOR, 8'hA5);
    wb_sel_i <= 4'h1;
    wb(0, baud_pkg::IDX_DIVISOR, 0);
    cmp("masked write", 0, rd);
    wb(0, 8'hFF, 8'h5A);
    cmp("unmapped", 0, rd);
    for (int m = 0; m < 5; m++) begin
      d = (m == 4) ? 255 : $random(seed) & 15;
      t = mtx[m] | (8'($random(seed)) & 8'hE1);
      shift_reg_empty <= 1'($random(seed));
      wb(1, baud_pkg::IDX_TX_CTRL, t);
      wb(1, baud_pkg::IDX_DIVISOR, d[7:0]);
      to_tick(1);
      cmp("first tick", mp[m] * (d + 1) + 1, k);
      @(posedge mclk);
      to_tick(1);
      cmp("tick period", mp[m] * (d + 1), k);
      wb(0, baud_pkg::IDX_TX_CTRL, 0);
      cmp("tx", {24'h0, t & baud_pkg::TX_WRITE_MASK | {6'h0, shift_reg_empty, 1'b0}}, rd);
      cmp("tx port", {24'h0, t & baud_pkg::TX_WRITE_MASK | {6'h0, shift_reg_empty, 1'b0}},
          {24'h0, transmit_control_status});
      wb(0, baud_pkg::IDX_DIVISOR, 0);
      cmp("divisor", d, rd);
      cmp("divisor port", d, {24'h0, bit_rate_divisor});
      wb(0, baud_pkg::IDX_RATE_STATUS, 0);
      cmp("rate status", {1'b1, t[4], t[2], 7'(mp[m])}, rd[23:14]);
      $display("rate test %0d done", m);
    end
    wb(1, baud_pkg::IDX_DIVISOR, 0);
    for (int i = 0; i < 6; i++) begin
      receive_data_pin <= 1'($random(seed));
      {framing_error, overrun_error, rx_bit9} <= 3'($random(seed));
      wb(1, baud_pkg::IDX_RX_CTRL, 8'($random(seed)));
      to_tick(0);
      @(posedge mclk);
      to_tick(1);
      @(posedge mclk);
      to_tick(1);
      cmp("rx level", receive_data_pin, rx_sample_level);
      t = wb_dat_i[7:0] & baud_pkg::RX_WRITE_MASK | {5'h0, framing_error, overrun_error, rx_bit9};
      wb(0, baud_pkg::IDX_RX_CTRL, 0);
      cmp("rx", {24'h0, t}, rd);
      cmp("rx port", {24'h0, t}, {24'h0, receive_control_status});
    end
    // a one-cycle glitch reaches at most one of the three samples
    for (int g = 0; g < 4; g++) begin
      to_tick(0);
      repeat (g) @(posedge mclk);
      receive_data_pin <= ~receive_data_pin;
      @(posedge mclk);
      receive_data_pin <= ~receive_data_pin;
      for (int j = 0; j < 8; j++) begin
        @(posedge mclk);
        cmp("rx glitch", receive_data_pin, rx_sample_level);
      end
    end
    $display("sampling test done");
    wb(1, baud_pkg::IDX_DIVISOR, 8'h5A);
    check_reset();
    finish_test();
  end
endmodule : tb
bind serial_baud_rate_generator baud_checker #(.ADDR_W(ADDR_W)) chk (.*);
